// ---- verilog/feac_tx_pkg.sv ----
// Constants shared by the transmit far-end alarm code controller.
//==============================================================================
// Operation
// - Rising edge of load bit captures mode, code A and code B.
// - A new load halts any codeword under way and restarts sending.
// - Mode 00 sends only continuous ones, no codeword.
// - Mode 01 sends code A ten times, then continuous ones.
// - Mode 10 sends code A ten times, code B ten times, then ones.
// - Mode 11 repeats code A until another mode is loaded.
// - Code B sits in bits 13..8, lowest bit sent first.
// - Code A sits in bits 5..0, lowest bit sent first.
// - Live idle bit is 1 while sending ones, 0 while sending a codeword.
// - Latched idle flag sets on live idle rising, holds until cleared.
// - Latched idle flag is forced to one right after reset.
// - Interrupt only when latched flag, its enable and port enable are set.
// - Control resets to bit 11 set; codes and enable reset to zero.
package feac_tx_pkg;
    localparam logic [7:0] ADDR_CONTROL = 8'hc0;
    localparam logic [7:0] ADDR_CODES = 8'hc2;
    localparam logic [7:0] ADDR_STATUS = 8'hc4;
    localparam logic [7:0] ADDR_LATCHED = 8'hc6;
    localparam logic [7:0] ADDR_IRQ_EN = 8'hc8;
    localparam logic [15:0] CONTROL_RESET = 16'h0800;
    localparam logic [15:0] CODES_RESET = 16'h0000;
    localparam logic [15:0] CONTROL_WMASK = 16'h0007;
    localparam logic [15:0] CODES_WMASK = 16'h3f3f;
    localparam int LOAD_BIT = 2;
    localparam int MODE_LSB = 0;
    localparam int CODE_A_LSB = 0;
    localparam int CODE_B_LSB = 8;
    localparam int IDLE_BIT = 0;
    localparam int CODE_REPEAT = 10;
    localparam int WORD_BITS = 16;
    typedef enum logic [1:0] {
        MODE_IDLE = 2'h0,
        MODE_SINGLE = 2'h1,
        MODE_DUAL = 2'h2,
        MODE_CONT = 2'h3
    } mode_e;
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_CODE_A = 2'h1,
        ST_CODE_B = 2'h3
    } state_e;
endpackage

// ---- verilog/feac_tx_if.sv ----
// Interface between the register file and the codeword serialiser.
`timescale 1ns/1ps
`default_nettype none
interface feac_tx_if;
    logic start;
    logic [1:0] mode;
    logic [5:0] code_a;
    logic [5:0] code_b;
    logic idle;
    modport regs (output start, output mode, output code_a, output code_b, input idle);
    modport ser (input start, input mode, input code_a, input code_b, output idle);
endinterface
`default_nettype wire

// ---- verilog/feac_tx_serializer.sv ----
// Codeword serialiser: mode sequencing and bit-by-bit output.
`timescale 1ns/1ps
`default_nettype none
module feac_tx_serializer
    import feac_tx_pkg::*;
(
    input wire logic i_clk, // Core clock.
    input wire logic i_rst, // Synchronous reset, active high.
    feac_tx_if.ser link, // Load and status link.
    output logic o_bit // Serial alarm channel bit.
);
    state_e state, next_state;
    logic [3:0] bit_idx, next_bit_idx;
    logic [3:0] rep, next_rep;
    logic [1:0] mode, next_mode;
    logic [5:0] code_a, next_code_a;
    logic [5:0] code_b, next_code_b;
    logic out_bit, next_out_bit;
    logic [5:0] cur;
    logic [15:0] word;

    always_comb begin
        next_state = state;
        next_bit_idx = bit_idx;
        next_rep = rep;
        next_mode = mode;
        next_code_a = code_a;
        next_code_b = code_b;
        if (link.start) begin
            // Load wins over whatever word is half sent.
            next_mode = link.mode;
            next_code_a = link.code_a;
            next_code_b = link.code_b;
            next_bit_idx = 4'h0;
            next_rep = 4'h0;
            next_state = (link.mode == MODE_IDLE) ? ST_IDLE : ST_CODE_A;
        end else if (state != ST_IDLE) begin
            next_bit_idx = bit_idx + 4'h1;
            if (bit_idx == 4'(WORD_BITS - 1)) begin
                next_rep = rep + 4'h1;
                if (mode == MODE_CONT) begin
                    next_rep = 4'h0;
                end else if (rep == 4'(CODE_REPEAT - 1)) begin
                    next_rep = 4'h0;
                    if (state == ST_CODE_A && mode == MODE_DUAL) begin
                        next_state = ST_CODE_B;
                    end else begin
                        next_state = ST_IDLE;
                    end
                end
            end
        end
        // The word is built from the next values so a fresh load shows its leading zero at once.
        cur = (next_state == ST_CODE_B) ? next_code_b : next_code_a;
        // Lowest code bit goes out first, right after the leading zero.
        word = {8'hff, 1'b0, cur, 1'b0};
        next_out_bit = (next_state == ST_IDLE) ? 1'b1 : word[next_bit_idx];
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state <= ST_IDLE;
            bit_idx <= 4'h0;
            rep <= 4'h0;
            mode <= 2'h0;
            code_a <= 6'h00;
            code_b <= 6'h00;
            out_bit <= 1'b1;
        end else begin
            state <= next_state;
            bit_idx <= next_bit_idx;
            rep <= next_rep;
            mode <= next_mode;
            code_a <= next_code_a;
            code_b <= next_code_b;
            out_bit <= next_out_bit;
        end
    end

    // The line bit is registered, and idle follows the state of the bit now on the line.
    assign o_bit = out_bit;
    assign link.idle = (state == ST_IDLE);
endmodule
`default_nettype wire

// ---- verilog/feac_tx_top.sv ----
// Transmit far-end alarm code controller: registers and status.
`timescale 1ns/1ps
`default_nettype none
module feac_tx_top
    import feac_tx_pkg::*;
(
    input wire logic I_CORE_CLK, // Core clock, 25 MHz.
    input wire logic I_RESET, // Synchronous reset, active high.
    input wire logic [7:0] I_ADDR, // Register byte address.
    input wire logic I_WR, // Write strobe, one cycle.
    input wire logic I_RD, // Read strobe, one cycle.
    input wire logic [15:0] I_WDATA, // Write data.
    input wire logic I_PORT_IRQ_EN, // Global per-port status interrupt enable.
    output logic [15:0] O_RDATA, // Registered read data.
    output logic O_TX_BIT, // Serial alarm channel bit.
    output logic O_IRQ // Interrupt request, level.
);
    //==========================================================================
    // Registers
    logic [15:0] control, next_control;
    logic [15:0] codes, next_codes;
    logic idle_latched, next_idle_latched;
    logic irq_en, next_irq_en;
    logic idle_prev, next_idle_prev;
    logic [15:0] rdata, next_rdata;
    logic load_rise;
    feac_tx_if link();

    always_comb begin
        next_control = control;
        next_codes = codes;
        next_irq_en = irq_en;
        next_idle_latched = idle_latched;
        next_idle_prev = link.idle;
        next_rdata = rdata;
        load_rise = 1'b0;
        if (I_WR) begin
            if (I_ADDR == ADDR_CONTROL) begin
                next_control = (control & ~CONTROL_WMASK) | (I_WDATA & CONTROL_WMASK);
                load_rise = I_WDATA[LOAD_BIT] & ~control[LOAD_BIT];
            end
            if (I_ADDR == ADDR_CODES) begin
                next_codes = I_WDATA & CODES_WMASK;
            end
            if (I_ADDR == ADDR_IRQ_EN) begin
                next_irq_en = I_WDATA[IDLE_BIT];
            end
            if (I_ADDR == ADDR_LATCHED && I_WDATA[IDLE_BIT]) begin
                next_idle_latched = 1'b0;
            end
        end
        if (link.idle && !idle_prev) begin
            next_idle_latched = 1'b1;
        end
        if (I_RD) begin
            case (I_ADDR)
                ADDR_CONTROL: next_rdata = control;
                ADDR_CODES: next_rdata = codes;
                ADDR_STATUS: next_rdata = {15'h0000, link.idle};
                ADDR_LATCHED: next_rdata = {15'h0000, idle_latched};
                ADDR_IRQ_EN: next_rdata = {15'h0000, irq_en};
                default: next_rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge I_CORE_CLK) begin
        if (I_RESET) begin
            control <= CONTROL_RESET;
            codes <= CODES_RESET;
            irq_en <= 1'b0;
            idle_latched <= 1'b1;
            idle_prev <= 1'b1;
            rdata <= 16'h0000;
        end else begin
            control <= next_control;
            codes <= next_codes;
            irq_en <= next_irq_en;
            idle_latched <= next_idle_latched;
            idle_prev <= next_idle_prev;
            rdata <= next_rdata;
        end
    end

    assign link.start = load_rise;
    assign link.mode = I_WDATA[MODE_LSB +: 2];
    assign link.code_a = codes[CODE_A_LSB +: 6];
    assign link.code_b = codes[CODE_B_LSB +: 6];

    feac_tx_serializer u_ser (
        .i_clk(I_CORE_CLK),
        .i_rst(I_RESET),
        .link(link),
        .o_bit(O_TX_BIT)
    );

    assign O_IRQ = idle_latched & irq_en & I_PORT_IRQ_EN;
    assign O_RDATA = rdata;
endmodule
`default_nettype wire

// ---- sim/feac_far_end.sv ----
// Far-end receiver model that decodes alarm codewords off the line.
`timescale 1ns/1ps
`default_nettype none
module feac_far_end (
    input wire logic i_clk, // Line clock.
    input wire logic i_bit, // Line bit.
    output logic o_valid, // Codeword seen.
    output logic [5:0] o_code // Decoded code.
);
    logic [15:0] sr = 16'hffff;
    always @(posedge i_clk) sr <= {sr[14:0], i_bit};
    // Eight ones after the second zero only close a whole word, so a cut-off word is never taken.
    assign o_valid = !sr[15] && !sr[8] && sr[7:0] == 8'hff;
    assign o_code = {sr[9], sr[10], sr[11], sr[12], sr[13], sr[14]};
endmodule
`default_nettype wire

// ---- sim/feac_tx_top_props.sv ----
// Port checker for the transmit alarm code controller.
`timescale 1ns/1ps
`default_nettype none
module feac_tx_top_props
    import feac_tx_pkg::*;
(
    input wire logic I_CORE_CLK, // Clock.
    input wire logic I_RESET, // Reset.
    input wire logic [7:0] I_ADDR, // Address.
    input wire logic I_WR, // Write.
    input wire logic I_RD, // Read.
    input wire logic [15:0] I_WDATA, // Write data.
    input wire logic I_PORT_IRQ_EN, // Port enable.
    input wire logic [15:0] O_RDATA, // Read data.
    input wire logic O_TX_BIT, // Line bit.
    input wire logic O_IRQ // Interrupt.
);
    logic ld_bit;
    logic [5:0] ca;
    logic load;
    assign load = I_WR && I_ADDR == ADDR_CONTROL && I_WDATA[LOAD_BIT] && !ld_bit;
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RESET) begin
            ld_bit <= 1'b0;
        end else if (I_WR && I_ADDR == ADDR_CONTROL) begin
            ld_bit <= I_WDATA[LOAD_BIT];
        end
        if (I_WR && I_ADDR == ADDR_CODES) begin
            ca <= I_WDATA[5:0];
        end
    end
    default clocking @(posedge I_CORE_CLK); endclocking
    default disable iff (I_RESET);
    AST_RESET_STATE: assert property ($fell(I_RESET) |-> O_TX_BIT && !O_IRQ)
        else $error("outputs not idle after reset");
    AST_IRQ_GATE: assert property (!I_PORT_IRQ_EN |-> !O_IRQ)
        else $error("interrupt without port enable");
    AST_IRQ_DISABLE: assert property (I_WR && I_ADDR == ADDR_IRQ_EN && !I_WDATA[0] |=> !O_IRQ)
        else $error("interrupt after enable cleared");
    AST_MODE_IDLE: assert property (load && I_WDATA[1:0] == 2'h0 |=> O_TX_BIT [*2])
        else $error("idle mode sent a zero");
    AST_FRAME: assert property (load && I_WDATA[1:0] != 2'h0 |=> !O_TX_BIT ##7 !O_TX_BIT ##1 O_TX_BIT [*8])
        else $error("codeword framing wrong");
    AST_CODE_A: assert property (load && I_WDATA[1:0] != 2'h0 |=> ##1 O_TX_BIT == ca[0] ##1 O_TX_BIT == ca[1]
        ##1 O_TX_BIT == ca[2] ##1 O_TX_BIT == ca[3] ##1 O_TX_BIT == ca[4] ##1 O_TX_BIT == ca[5])
        else $error("code bits out of order");
    AST_CTRL_READ: assert property (I_RD && I_ADDR == ADDR_CONTROL |=> O_RDATA[15:3] == 13'h0100)
        else $error("control upper bits wrong");
    AST_STATUS_BUSY: assert property (I_RD && I_ADDR == ADDR_STATUS && !O_TX_BIT |=> O_RDATA == 16'h0000)
        else $error("idle reported during codeword");
    cover property (load && I_WDATA[1:0] == 2'h3);
    cover property (O_IRQ);
    cover property (I_RD && I_ADDR == ADDR_STATUS && !O_TX_BIT);
endmodule
bind feac_tx_top feac_tx_top_props feac_tx_top_props_inst (.I_CORE_CLK(I_CORE_CLK), .I_RESET(I_RESET),
    .I_ADDR(I_ADDR), .I_WR(I_WR), .I_RD(I_RD), .I_WDATA(I_WDATA), .I_PORT_IRQ_EN(I_PORT_IRQ_EN),
    .O_RDATA(O_RDATA), .O_TX_BIT(O_TX_BIT), .O_IRQ(O_IRQ));
`default_nettype wire

// ---- sim/testbench.sv ----
// Self-checking bench for the transmit alarm code controller.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import feac_tx_pkg::*;
    logic clk = 1'b0;
    logic rst, wen, ren, pen, tx_bit, irq, fe_valid;
    logic [7:0] addr;
    logic [15:0] wdata, rdata;
    logic [5:0] fe_code, a, b, c;
    logic rd_seen = 1'b0;
    logic [15:0] rq[$];
    logic [5:0] cq[$];
    int num_errors = 0;
    int checks_done = 0;
    feac_tx_top feac_tx_top_inst (.I_CORE_CLK(clk), .I_RESET(rst), .I_ADDR(addr), .I_WR(wen), .I_RD(ren),
        .I_WDATA(wdata), .I_PORT_IRQ_EN(pen), .O_RDATA(rdata), .O_TX_BIT(tx_bit), .O_IRQ(irq));
    feac_far_end feac_far_end_inst (.i_clk(clk), .i_bit(tx_bit), .o_valid(fe_valid), .o_code(fe_code));
    initial begin
        forever #20 clk = ~clk;
    end
    task compare(input string name, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    task close_out;
        if (num_errors == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task wr(input logic [7:0] ad, input logic [15:0] d);
        {addr, wdata, wen} = {ad, d, 1'b1};
        cyc(1);
        wen = 1'b0;
        cyc(1);
    endtask
    task rd(input logic [7:0] ad, input logic [15:0] e);
        rq.push_back(e);
        {addr, ren} = {ad, 1'b1};
        cyc(1);
        ren = 1'b0;
        cyc(1);
    endtask
    // Load needs the load bit written low first, since only its rising edge counts.
    task send(input logic [1:0] m, input logic [5:0] x, input logic [5:0] y, input int n);
        wr(ADDR_CODES, {2'h0, y, 2'h0, x});
        wr(ADDR_CONTROL, {14'h0, m});
        wr(ADDR_CONTROL, {13'h0, 1'b1, m});
        repeat (n) cq.push_back(x);
    endtask
    always @(posedge clk) rd_seen <= ren;
    always @(negedge clk) begin
        if (rd_seen) compare("rdata", rq.pop_front(), rdata);
        if (fe_valid === 1'b1) compare("code", cq.size() ? {10'h0, cq.pop_front()} : 16'hffff, {10'h0, fe_code});
    end
    initial begin
        #(40 * 4000);
        num_errors++;
        close_out;
    end
    initial begin
        {rst, wen, ren, pen, addr, wdata} = {1'b1, 27'h0};
        void'($urandom(9));
        a = 6'($urandom()) & 6'h3e;
        b = 6'($urandom());
        c = 6'($urandom());
        cyc(6);
        rst = 1'b0;
        rd(ADDR_CONTROL, CONTROL_RESET);
        rd(ADDR_CODES, CODES_RESET);
        rd(ADDR_IRQ_EN, 16'h0000);
        rd(ADDR_STATUS, 16'h0001);
        rd(ADDR_LATCHED, 16'h0001);
        rd(8'hca, 16'h0000);
        wr(ADDR_CONTROL, 16'hfff8);
        rd(ADDR_CONTROL, CONTROL_RESET);
        pen = 1'b1;
        wr(ADDR_IRQ_EN, 16'h0001);
        compare("irq", 16'h0001, {15'h0, irq});
        pen = 1'b0;
        cyc(1);
        compare("irq", 16'h0000, {15'h0, irq});
        pen = 1'b1;
        wr(ADDR_LATCHED, 16'h0001);
        rd(ADDR_LATCHED, 16'h0000);
        compare("irq", 16'h0000, {15'h0, irq});
        send(MODE_SINGLE, a, b, 10);
        rd(ADDR_STATUS, 16'h0000);
        cyc(170);
        rd(ADDR_LATCHED, 16'h0001);
        compare("irq", 16'h0001, {15'h0, irq});
        wr(ADDR_IRQ_EN, 16'h0000);
        rd(ADDR_STATUS, 16'h0001);
        send(MODE_DUAL, a, b, 10);
        repeat (10) cq.push_back(b);
        cyc(330);
        send(MODE_CONT, c, a, 3);
        cyc(48);
        send(MODE_SINGLE, b, a, 10);
        cyc(170);
        send(MODE_SINGLE, a, b, 1);
        cyc(16);
        send(MODE_IDLE, c, c, 0);
        cyc(40);
        rd(ADDR_STATUS, 16'h0001);
        compare("pending", 16'h0000, 16'(cq.size()));
        close_out;
    end
endmodule
`default_nettype wire
